// ===== rtl/uiaw_core.sv
// Interrupt, error flag, address detect and wake logic of the serial port
`timescale 1ns/1ps
module uiaw_core
  import uiaw_pkg::*;
#(
  parameter int SETTLE = UIAW_SETTLE_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_WORD_DONE,
  input  wire logic [8:0]  RX_WORD,
  input  wire logic        RX_PARITY_BIT,
  input  wire logic [1:0]  RX_STOP_BITS,
  input  wire logic        RX_OVERRUN,
  input  wire logic        TX_EMPTY_EV,
  input  wire logic        TX_IDLE_EV,
  input  wire logic        RX_LINE,
  input  wire logic        STACK_FULL,
  output logic             IRQ_B,
  output logic             XFER_RUN,
  output logic             WAKE_UP
);
  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] status_q, ctrl1_q, ctrl2_q, baud_q, sys_q;
  logic [8:0] data_q;
  logic       stat_seen_q, rx_line_q, settle_on_q, armed_q, pend_q;
  logic [15:0] settle_q;
  logic [31:0] prdata_q;
  logic        irq_b_q;

  wire access  = PSEL && PENABLE;
  wire wr      = access && PWRITE;
  wire rd      = access && !PWRITE;
  wire clk_on  = sys_q[SY_CLKON];
  wire settled = !settle_on_q;
  wire irq_gate = sys_q[SY_EMI] && sys_q[SY_PRI] && sys_q[SY_PIE] &&
                  !STACK_FULL;

  // Parity of the received word, selected type
  function automatic logic par_bad(input logic [8:0] w, input logic nine,
                                   input logic odd, input logic pb);
    logic p;
    p = nine ? ^w : ^w[7:0];
    par_bad = (p ^ pb) != odd;
  endfunction : par_bad

  // Receive word is taken only with clock running and settled
  wire rx_ok = RX_WORD_DONE && clk_on && settled;
  wire top_bit = ctrl1_q[C1_NINE] ? RX_WORD[8] : RX_WORD[7];
  wire sa_rd = rd && PADDR == UIAW_OFF_STATUS;
  wire da_rd = rd && PADDR == UIAW_OFF_DATA;
  wire clr_rx = da_rd && stat_seen_q;
  wire clr_tx = wr && PADDR == UIAW_OFF_DATA && stat_seen_q;

  // ************************************************************
  // APB slave
  // ************************************************************
  // Zero wait states; unmapped reads return zero, with error only above UIAW_OFF_SYS
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      prdata_q <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        UIAW_OFF_STATUS: prdata_q <= {24'h000000, status_q};
        UIAW_OFF_CTRL1:  prdata_q <= {24'h000000, ctrl1_q};
        UIAW_OFF_CTRL2:  prdata_q <= {24'h000000, ctrl2_q};
        UIAW_OFF_DATA:   prdata_q <= {23'h000000, data_q};
        UIAW_OFF_BAUD:   prdata_q <= {24'h000000, baud_q};
        UIAW_OFF_SYS:    prdata_q <= {24'h000000, sys_q};
        default:         prdata_q <= 32'h00000000;
      endcase
    end
  end
  assign PRDATA  = prdata_q;
  assign PREADY  = 1'b1;
  assign PSLVERR = access && PADDR > UIAW_OFF_SYS;

  // Control registers; power down touches none of them
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ctrl1_q <= UIAW_CTRL_RST;
      ctrl2_q <= UIAW_CTRL_RST;
      baud_q  <= UIAW_BAUD_RST;
      sys_q   <= UIAW_SYS_RST;
    end else if (wr) begin
      if (PADDR == UIAW_OFF_CTRL1) ctrl1_q <= PWDATA[7:0];
      if (PADDR == UIAW_OFF_CTRL2) ctrl2_q <= PWDATA[7:0];
      if (PADDR == UIAW_OFF_BAUD)  baud_q  <= PWDATA[7:0];
      if (PADDR == UIAW_OFF_SYS)   sys_q   <= PWDATA[7:0];
    end
  end

  // Status read arms the clear sequence for flags
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      stat_seen_q <= 1'b0;
    end else if (sa_rd) begin
      stat_seen_q <= 1'b1;
    end else if (clr_rx || clr_tx) begin
      stat_seen_q <= 1'b0;
    end
  end

  // ************************************************************
  // Receive data and status flags
  // ************************************************************
  // Data held; only a new word changes it
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      data_q <= 9'h000;
    end else if (rx_ok) begin
      data_q <= RX_WORD;
    end
  end

  // Flags are read-only; set wins over the access clear
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      status_q <= 8'h30;
    end else begin
      if (clr_rx) begin
        status_q[ST_PARITY_ERROR_FLAG] <= 1'b0;
        status_q[ST_FRAMING_ERROR_FLAG] <= 1'b0;
        status_q[ST_OERR] <= 1'b0;
        status_q[ST_RECEIVE_DATA_FLAG] <= 1'b0;
      end
      if (clr_tx) begin
        status_q[ST_TXIF]  <= 1'b0;
        status_q[ST_TIDLE] <= 1'b0;
      end
      if (rx_ok) begin
        status_q[ST_RECEIVE_DATA_FLAG] <= 1'b1;
        if (ctrl1_q[C1_PARITY_ENABLE] &&
            par_bad(RX_WORD, ctrl1_q[C1_NINE], ctrl1_q[C1_ODD],
                    RX_PARITY_BIT))
          status_q[ST_PARITY_ERROR_FLAG] <= 1'b1;
        if (!RX_STOP_BITS[0] ||
            (ctrl1_q[C1_TWOST] && !RX_STOP_BITS[1]))
          status_q[ST_FRAMING_ERROR_FLAG] <= 1'b1;
      end
      if (RX_OVERRUN && clk_on && settled) status_q[ST_OERR] <= 1'b1;
      if (TX_EMPTY_EV && clk_on) status_q[ST_TXIF]  <= 1'b1;
      if (TX_IDLE_EV && clk_on)  status_q[ST_TIDLE] <= 1'b1;
      status_q[ST_AWAKE] <= settle_on_q;
      status_q[7] <= 1'b0;
    end
  end

  // ************************************************************
  // Power down and wake
  // ************************************************************
  // Arm on entry to power down with clock off
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      armed_q <= 1'b0;
    end else if (sys_q[SY_PDN] && !clk_on && !armed_q && !settle_on_q) begin
      armed_q <= ctrl2_q[C2_WAKE] && ctrl1_q[C1_EN] && ctrl2_q[C2_RECEIVER_ON] &&
                 ctrl2_q[C2_RIE];
    end else if (clk_on || WAKE_UP) begin
      armed_q <= 1'b0;
    end
  end

  // Receive line history for falling edge
  always_ff @(posedge CLK) begin
    if (!RST_B) rx_line_q <= 1'b1;
    else        rx_line_q <= RX_LINE;
  end
  wire fall = rx_line_q && !RX_LINE;

  // Wake pulse and settling counter
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      WAKE_UP     <= 1'b0;
      settle_on_q <= 1'b0;
      settle_q    <= 16'h0000;
    end else begin
      WAKE_UP <= armed_q && fall && !WAKE_UP;
      if (WAKE_UP) begin
        settle_on_q <= 1'b1;
        settle_q    <= 16'(SETTLE);
      end else if (settle_on_q) begin
        if (settle_q <= 16'h0001) settle_on_q <= 1'b0;
        settle_q <= settle_q - 16'h0001;
      end
    end
  end

  // Wake interrupt deferred until settled
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      pend_q <= 1'b0;
    end else if (WAKE_UP && ctrl2_q[C2_RIE]) begin
      pend_q <= 1'b1;
    end else if (settled) begin
      pend_q <= 1'b0;
    end
  end

  // Transfer runs only while clock present
  always_ff @(posedge CLK) begin
    if (!RST_B) XFER_RUN <= 1'b0;
    else        XFER_RUN <= clk_on && ctrl1_q[C1_EN];
  end

  // ************************************************************
  // Interrupt request
  // ************************************************************
  logic ev_rx, ev_or, ev_te, ev_ti, ev_ad, ev_wk, any_ev;
  always_comb begin
    // Address detect filters data-available
    ev_rx = rx_ok && ctrl2_q[C2_RIE] &&
            (!ctrl2_q[C2_ADDRESS_DETECT_ENABLE] || top_bit);
    ev_or = RX_OVERRUN && clk_on && settled && ctrl2_q[C2_RIE];
    ev_te = TX_EMPTY_EV && clk_on && ctrl2_q[C2_TEIE];
    ev_ti = TX_IDLE_EV && clk_on && ctrl2_q[C2_TIIE];
    ev_ad = rx_ok && ctrl2_q[C2_ADDRESS_DETECT_ENABLE] && top_bit;
    ev_wk = pend_q && settled;
    any_ev = ev_rx || ev_or || ev_te || ev_ti || ev_ad || ev_wk;
  end

  // One-cycle low pulse per cycle with any event, gated by enables; events in the same cycle share one pulse
  always_ff @(posedge CLK) begin
    if (!RST_B) irq_b_q <= 1'b1;
    else        irq_b_q <= !(any_ev && irq_gate);
  end
  assign IRQ_B = irq_b_q;

  // ************************************************************
  // Checks
  // ************************************************************
  a_irq_pulse_one: assert property (@(posedge CLK) disable iff (!RST_B)
    !IRQ_B |=> IRQ_B || $past(any_ev))
    else $error("irq low without event");
  a_irq_gated: assert property (@(posedge CLK) disable iff (!RST_B)
    !IRQ_B |-> $past(irq_gate))
    else $error("irq while disabled");
  a_parity_set: assert property (@(posedge CLK) disable iff (!RST_B)
    rx_ok && !ctrl1_q[C1_PARITY_ENABLE] && !status_q[ST_PARITY_ERROR_FLAG] && !clr_rx
    |=> !status_q[ST_PARITY_ERROR_FLAG])
    else $error("parity flag with parity off");
  a_frame_set: assert property (@(posedge CLK) disable iff (!RST_B)
    rx_ok && !RX_STOP_BITS[0] |=> status_q[ST_FRAMING_ERROR_FLAG])
    else $error("framing flag missed");
  a_addr_filter: assert property (@(posedge CLK) disable iff (!RST_B)
    rx_ok && ctrl2_q[C2_ADDRESS_DETECT_ENABLE] && !top_bit && !ev_or && !ev_te &&
    !ev_ti && !ev_wk |=> IRQ_B)
    else $error("data irq without address bit");
  a_rx_irq: assert property (@(posedge CLK) disable iff (!RST_B)
    rx_ok && !ctrl2_q[C2_ADDRESS_DETECT_ENABLE] && ctrl2_q[C2_RIE] && irq_gate
    |=> !IRQ_B)
    else $error("data irq missed");
  a_settle_quiet: assert property (@(posedge CLK) disable iff (!RST_B)
    settle_on_q && RX_WORD_DONE |=> $stable(data_q))
    else $error("data taken while settling");
  a_wake_hold: assert property (@(posedge CLK) disable iff (!RST_B)
    settle_on_q |-> !ev_wk)
    else $error("wake irq before settling");
  a_flag_kept: assert property (@(posedge CLK) disable iff (!RST_B)
    status_q[ST_RECEIVE_DATA_FLAG] && !clr_rx |=> status_q[ST_RECEIVE_DATA_FLAG])
    else $error("flag lost without clear");
  a_wake_pulse: assert property (@(posedge CLK) disable iff (!RST_B)
    armed_q && fall && !WAKE_UP |=> WAKE_UP ##1 settle_on_q)
    else $error("wake missed");
  c_rx_irq:   cover property (@(posedge CLK) ev_rx && irq_gate);
  c_addr:     cover property (@(posedge CLK) ev_ad && irq_gate);
  c_wake_irq: cover property (@(posedge CLK) ev_wk && irq_gate);
  c_tx_irq:   cover property (@(posedge CLK) ev_te && irq_gate);
endmodule : uiaw_core

// ===== shared/uiaw_pkg.sv
// Package of constants and register map for the port interrupt/wake block
package uiaw_pkg;
  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] UIAW_OFF_STATUS = 8'h00;
  localparam logic [7:0] UIAW_OFF_CTRL1  = 8'h04;
  localparam logic [7:0] UIAW_OFF_CTRL2  = 8'h08;
  localparam logic [7:0] UIAW_OFF_DATA   = 8'h0C;
  localparam logic [7:0] UIAW_OFF_BAUD   = 8'h10;
  localparam logic [7:0] UIAW_OFF_SYS    = 8'h14;
  // ************************************************************
  // Field positions
  // ************************************************************
  // Status
  localparam int ST_PARITY_ERROR_FLAG  = 0;
  localparam int ST_FRAMING_ERROR_FLAG  = 1;
  localparam int ST_OERR  = 2;
  localparam int ST_RECEIVE_DATA_FLAG  = 3;
  localparam int ST_TIDLE = 4;
  localparam int ST_TXIF  = 5;
  localparam int ST_AWAKE = 6;
  // Control one
  localparam int C1_EN    = 7;
  localparam int C1_NINE  = 6;
  localparam int C1_PARITY_ENABLE  = 5;
  localparam int C1_ODD   = 4;
  localparam int C1_TWOST = 3;
  // Control two
  localparam int C2_TXEN  = 7;
  localparam int C2_RECEIVER_ON  = 6;
  localparam int C2_ADDRESS_DETECT_ENABLE = 3;
  localparam int C2_WAKE  = 2;
  localparam int C2_RIE   = 1;
  localparam int C2_TIIE  = 0;
  localparam int C2_TEIE  = 4;
  // System control
  localparam int SY_EMI   = 0;
  localparam int SY_PRI   = 1;
  localparam int SY_PIE   = 2;
  localparam int SY_CLKON = 3;
  localparam int SY_PDN   = 4;
  // ************************************************************
  // Reset values and timing
  // ************************************************************
  localparam logic [7:0] UIAW_CTRL_RST = 8'h00;
  localparam logic [7:0] UIAW_SYS_RST  = 8'h08;
  localparam logic [7:0] UIAW_BAUD_RST = 8'h00;
  localparam int UIAW_SETTLE_NS   = 160;
  localparam int UIAW_CLK_MHZ     = 100;
  localparam int UIAW_SETTLE_CYC  = (UIAW_SETTLE_NS * UIAW_CLK_MHZ) / 1000;
endpackage : uiaw_pkg

// ===== tb/uiaw_core_tb_top.sv
// Self-checking bench for the port interrupt and wake block
`timescale 1ns/1ps
module uiaw_core_tb_top;
  import uiaw_pkg::*;
  localparam int ST = 12;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic        irq_b, xfer_run, wake_up, stack_full, tx_empty, tx_idle;
  logic        done, par, ovr, line;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0]  word;
  logic [1:0]  stops;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          w_n, i_n, w_at, i_at;
  uiaw_core #(.SETTLE(ST)) u_dut (.CLK(clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_WORD_DONE(done), .RX_WORD(word), .RX_PARITY_BIT(par),
    .RX_STOP_BITS(stops), .RX_OVERRUN(ovr), .TX_EMPTY_EV(tx_empty),
    .TX_IDLE_EV(tx_idle), .RX_LINE(line), .STACK_FULL(stack_full),
    .IRQ_B(irq_b), .XFER_RUN(xfer_run), .WAKE_UP(wake_up));
  uiaw_rx_model u_rx (.clk(clk), .done(done), .word(word), .par(par),
    .stops(stops), .ovr(ovr), .line(line));
  // ****************************************************
  // Helpers
  // ****************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // A slave that never answers ends the run as a failure
    if (t >= 50) begin
      error_cnt++;
      end_sim();
    end
  endtask : apb
  // Count request pulses and wake pulses, noting the first of each
  task automatic watch(input int win);
    w_n = 0;
    i_n = 0;
    for (int c = 0; c < win; c++) begin
      @(posedge clk);
      if (wake_up === 1'b1 && w_n++ == 0) w_at = c;
      if (irq_b === 1'b0 && i_n++ == 0) i_at = c;
    end
  endtask : watch
  task automatic pulse_tx(input logic idle);
    @(posedge clk);
    if (idle) tx_idle <= 1'b1;
    else tx_empty <= 1'b1;
    @(posedge clk);
    tx_idle <= 1'b0;
    tx_empty <= 1'b0;
  endtask : pulse_tx
  // Status then data access empties the receive side
  task automatic clr();
    repeat (3) begin
      apb(1'b0, UIAW_OFF_STATUS, 32'h0);
      apb(1'b0, UIAW_OFF_DATA, 32'h0);
    end
  endtask : clr
  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_reset();
    apb(1'b1, UIAW_OFF_STATUS, 32'hFF);
    apb(1'b0, UIAW_OFF_STATUS, 32'h0);
    chk(rd, 32'h30);
    apb(1'b0, UIAW_OFF_SYS, 32'h0);
    chk(rd, 32'h08);
    apb(1'b0, 8'h18, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask : t_reset
  task automatic t_rx();
    apb(1'b1, UIAW_OFF_SYS, 32'h0F);
    apb(1'b1, UIAW_OFF_CTRL1, 32'h80);
    apb(1'b1, UIAW_OFF_CTRL2, 32'hC2);
    u_rx.send(9'h055, 1'b0, 2'h3);
    watch(4);
    chk(i_n, 1);
    u_rx.overrun();
    watch(4);
    chk(i_n, 1);
    stack_full <= 1'b1;
    u_rx.send(9'h011, 1'b0, 2'h3);
    watch(4);
    chk(i_n, 0);
    stack_full <= 1'b0;
    apb(1'b1, UIAW_OFF_CTRL2, 32'hC0);
    u_rx.send(9'h022, 1'b0, 2'h3);
    watch(4);
    chk(i_n, 0);
    watch(1);
    apb(1'b0, UIAW_OFF_STATUS, 32'h0);
    chk(rd & 32'h0C, 32'h0C);
    clr();
    apb(1'b0, UIAW_OFF_STATUS, 32'h0);
    chk(rd, 32'h30);
  endtask : t_rx
  task automatic t_addr();
    logic [8:0] w[5] = '{9'h07F, 9'h080, 9'h080, 9'h100, 9'h000};
    int exp[5] = '{0, 1, 0, 1, 1};
    apb(1'b1, UIAW_OFF_CTRL2, 32'hCA);
    for (int k = 0; k < 5; k++) begin
      if (k == 2) apb(1'b1, UIAW_OFF_CTRL1, 32'hC0);
      if (k == 4) apb(1'b1, UIAW_OFF_CTRL2, 32'hC2);
      u_rx.send(w[k], 1'b0, 2'h3);
      watch(4);
      chk(i_n, exp[k]);
      clr();
    end
  endtask : t_addr
  task automatic t_err();
    apb(1'b1, UIAW_OFF_CTRL1, 32'hA0);
    u_rx.send(9'h001, 1'b0, 2'h3);
    apb(1'b0, UIAW_OFF_STATUS, 32'h0);
    chk(rd[1:0], 32'h1);
    clr();
    apb(1'b1, UIAW_OFF_CTRL1, 32'h88);
    u_rx.send(9'h000, 1'b0, 2'h1);
    apb(1'b0, UIAW_OFF_STATUS, 32'h0);
    chk(rd[1:0], 32'h2);
    clr();
  endtask : t_err
  task automatic t_tx();
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, UIAW_OFF_CTRL2, k < 2 ? 32'h90 : 32'h81);
      pulse_tx(k[0]);
      watch(4);
      chk(i_n, k == 0 || k == 3);
    end
  endtask : t_tx
  // Wake with full gate, with gate off, and with wake enable off
  task automatic t_wake();
    logic [31:0] sys[3] = '{32'h17, 32'h10, 32'h17};
    logic [31:0] c2[3] = '{32'hC6, 32'hC6, 32'hC2};
    apb(1'b1, UIAW_OFF_CTRL1, 32'h80);
    apb(1'b1, UIAW_OFF_BAUD, 32'h5A);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, UIAW_OFF_CTRL2, c2[k]);
      apb(1'b1, UIAW_OFF_SYS, sys[k]);
      watch(2);
      chk(xfer_run, 1'b0);
      fork
        begin
          u_rx.fall();
          u_rx.send(9'h0AA, 1'b0, 2'h3);
        end
        watch(ST + 20);
      join
      chk(w_n, k != 2);
      chk(i_n, k == 0);
      if (k == 0) chk(i_at - w_at >= ST, 1);
      apb(1'b0, UIAW_OFF_STATUS, 32'h0);
      chk(rd[ST_RECEIVE_DATA_FLAG], 1'b0);
      // Clock back on, so the next pass enters power down afresh
      apb(1'b1, UIAW_OFF_SYS, 32'h0F);
    end
    apb(1'b0, UIAW_OFF_BAUD, 32'h0);
    chk(rd, 32'h5A);
    apb(1'b0, UIAW_OFF_CTRL2, 32'h0);
    chk(rd, 32'hC2);
    apb(1'b1, UIAW_OFF_SYS, 32'h0F);
    watch(2);
    chk(xfer_run, 1'b1);
  endtask : t_wake
  // ****************************************************
  // Main sequence and watchdog
  // ****************************************************
  initial begin
    {rst_b, psel, penable, pwrite, stack_full, tx_empty, tx_idle} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_rx();
    t_addr();
    t_err();
    t_tx();
    t_wake();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule : uiaw_core_tb_top

// ===== tb/uiaw_rx_model.sv
// Far-end word source: finished receive words and the receive line
`timescale 1ns/1ps
module uiaw_rx_model (
  input  wire logic       clk,
  output logic            done,
  output logic [8:0]      word,
  output logic            par,
  output logic [1:0]      stops,
  output logic            ovr,
  output logic            line
);
  // Line idles high; data lines carry no stale word
  initial begin
    done = 1'b0;
    word = 9'h1FF;
    par = 1'b1;
    stops = 2'h3;
    ovr = 1'b0;
    line = 1'b1;
  end
  // One finished word, shown for a single cycle only
  task automatic send(input logic [8:0] w, input logic p, input logic [1:0] s);
    @(posedge clk);
    done <= 1'b1;
    word <= w;
    par <= p;
    stops <= s;
    @(posedge clk);
    done <= 1'b0;
    word <= ~w;
    par <= ~p;
    stops <= ~s;
  endtask : send
  // Overrun event, shown for a single cycle only
  task automatic overrun();
    @(posedge clk);
    ovr <= 1'b1;
    @(posedge clk);
    ovr <= 1'b0;
  endtask : overrun
  // Start-bit edge, line back high after a short low
  task automatic fall();
    @(posedge clk);
    line <= 1'b0;
    repeat (3) @(posedge clk);
    line <= 1'b1;
  endtask : fall
endmodule : uiaw_rx_model
